// File: src/eac_host.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "eac_consts.svh"
// ****************************************
// CPU-side sequencer driven by software
// ****************************************
module eac_host #(
  parameter int ADDR_W = `EAC_ADDR_W
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  swAddr,
  input  wire logic [15:0] swWdata,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic      [15:0] swRdata,
  output logic             irq,
  eac_if.host              bus
);

  eac_pkg::eac_host_state_t stateReg;
  eac_pkg::eac_rd_state_t   rdStReg;
  logic              opWriteReg;
  logic              seenBusyReg;
  logic [ADDR_W-1:0] addrReg;
  logic [7:0]        dataReg;
  logic [7:0]        rdResultReg;
  logic [2:0]        statusReg;
  logic [2:0]        maskReg;
  logic [15:0]       swRdataReg;
  logic [2:0]        evSet;
  logic              go;

  // Software write to one of our registers
  function automatic logic swHit(input logic wr, input logic [2:0] a, input logic [2:0] t);
    swHit = wr && (a == t);
  endfunction : swHit

  // ****************************************
  // Link requests
  // ****************************************
  // Nothing is issued while the device stalls the core
  assign go = !bus.stall;

  always_comb begin
    bus.regSel   = `EAC_REG_CTRL;
    bus.regWdata = 8'h00;
    bus.regWr    = 1'b0;
    bus.regRd    = 1'b0;
    case (stateReg)
      eac_pkg::S_CHK, eac_pkg::S_DNC: begin
        bus.regRd = go;
      end
      eac_pkg::S_LDAL: begin
        bus.regSel   = `EAC_REG_ADDRL;
        bus.regWdata = addrReg[7:0];
        bus.regWr    = go;
      end
      eac_pkg::S_LDAH: begin
        bus.regSel   = `EAC_REG_ADDRH;
        bus.regWdata = 8'(addrReg[ADDR_W-1:8]);
        bus.regWr    = go;
      end
      eac_pkg::S_LDD: begin
        bus.regSel   = `EAC_REG_DATA;
        bus.regWdata = dataReg;
        bus.regWr    = go;
      end
      eac_pkg::S_ARM: begin
        bus.regWdata = 8'h01 << `EAC_BIT_MWE;
        bus.regWr    = go;
      end
      eac_pkg::S_STB: begin
        bus.regWdata = 8'h01 << `EAC_BIT_WE;
        bus.regWr    = go;
      end
      // Read strobe first, then fetch the data byte once the stall ends
      eac_pkg::S_RDS: begin
        if (rdStReg == eac_pkg::R_IDLE) begin
          bus.regWdata = 8'h01 << `EAC_BIT_RE;
          bus.regWr    = go;
        end else if (rdStReg == eac_pkg::R_FETCH) begin
          bus.regSel = `EAC_REG_DATA;
          bus.regRd  = go;
        end
      end
      default: begin
        bus.regWr = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Arm and strobe go out on consecutive cycles, never split
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stateReg <= eac_pkg::S_IDLE;
    end else begin
      case (stateReg)
        eac_pkg::S_IDLE: begin
          if (swHit(swWr, swAddr, `EAC_SW_CMD) && (swWdata[1:0] != 2'h0)) begin
            stateReg <= eac_pkg::S_CHK;
          end
        end
        eac_pkg::S_CHK:  if (go) stateReg <= eac_pkg::S_CHKW;
        eac_pkg::S_CHKW: begin
          if (bus.regRdata[`EAC_BIT_WE]
              || (opWriteReg && bus.selfProgBusy)) begin
            stateReg <= eac_pkg::S_CHK;
          end else begin
            stateReg <= eac_pkg::S_LDAL;
          end
        end
        eac_pkg::S_LDAL: if (go) stateReg <= eac_pkg::S_LDAH;
        eac_pkg::S_LDAH: begin
          if (go) stateReg <= opWriteReg ? eac_pkg::S_LDD : eac_pkg::S_RDS;
        end
        eac_pkg::S_LDD:  if (go) stateReg <= eac_pkg::S_ARM;
        eac_pkg::S_ARM:  if (go) stateReg <= eac_pkg::S_STB;
        eac_pkg::S_STB:  if (go) stateReg <= eac_pkg::S_DNC;
        eac_pkg::S_DNC:  if (go) stateReg <= eac_pkg::S_DNW;
        eac_pkg::S_DNW: begin
          stateReg <= bus.regRdata[`EAC_BIT_WE] ? eac_pkg::S_DNC : eac_pkg::S_IDLE;
        end
        eac_pkg::S_RDS:  if (rdStReg == eac_pkg::R_CAPT) stateReg <= eac_pkg::S_IDLE;
        default:         stateReg <= eac_pkg::S_IDLE;
      endcase
    end
  end

  // Operation kind and whether the write was seen running
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      opWriteReg  <= 1'b0;
      seenBusyReg <= 1'b0;
    end else if (stateReg == eac_pkg::S_IDLE) begin
      opWriteReg  <= swWdata[`EAC_CMD_WRITE];
      seenBusyReg <= 1'b0;
    end else if (stateReg == eac_pkg::S_DNW && bus.regRdata[`EAC_BIT_WE]) begin
      seenBusyReg <= 1'b1;
    end
  end

  // ****************************************
  // Read result capture
  // ****************************************
  // After the read strobe the stall runs out, then the data byte is fetched
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdStReg     <= eac_pkg::R_IDLE;
      rdResultReg <= 8'h00;
    end else begin
      case (rdStReg)
        eac_pkg::R_IDLE: begin
          if (stateReg == eac_pkg::S_RDS && go) rdStReg <= eac_pkg::R_FETCH;
        end
        eac_pkg::R_FETCH: begin
          if (go) rdStReg <= eac_pkg::R_CAPT;
        end
        eac_pkg::R_CAPT: begin
          rdResultReg <= bus.regRdata;
          rdStReg     <= eac_pkg::R_IDLE;
        end
        default: rdStReg <= eac_pkg::R_IDLE;
      endcase
    end
  end

  // ****************************************
  // Software registers and interrupt
  // ****************************************
  // Write completion, read completion, write that never started
  assign evSet[`EAC_ST_WDONE] = (stateReg == eac_pkg::S_DNW) && !bus.regRdata[`EAC_BIT_WE]
                                && seenBusyReg;
  assign evSet[`EAC_ST_RDONE] = (rdStReg == eac_pkg::R_CAPT);
  assign evSet[`EAC_ST_WFAIL] = (stateReg == eac_pkg::S_DNW) && !bus.regRdata[`EAC_BIT_WE]
                                && !seenBusyReg;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      statusReg <= 3'h0;
    end else if (swHit(swWr, swAddr, `EAC_SW_STATUS)) begin
      statusReg <= (statusReg & ~swWdata[2:0]) | evSet;
    end else begin
      statusReg <= statusReg | evSet;
    end
  end

  // Target and mask held by software; target is latched only when idle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addrReg <= '0;
      dataReg <= 8'h00;
      maskReg <= `EAC_RST_MASK;
    end else begin
      if (swHit(swWr, swAddr, `EAC_SW_ADDR) && stateReg == eac_pkg::S_IDLE) begin
        addrReg <= swWdata[ADDR_W-1:0];
      end
      if (swHit(swWr, swAddr, `EAC_SW_DATA) && stateReg == eac_pkg::S_IDLE) begin
        dataReg <= swWdata[7:0];
      end
      if (swHit(swWr, swAddr, `EAC_SW_MASK)) begin
        maskReg <= swWdata[2:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      swRdataReg <= 16'h0000;
    end else if (swRd) begin
      case (swAddr)
        `EAC_SW_ADDR:   swRdataReg <= 16'(addrReg);
        `EAC_SW_DATA:   swRdataReg <= {8'h00, dataReg};
        `EAC_SW_RDATA:  swRdataReg <= {8'h00, rdResultReg};
        `EAC_SW_STATUS: swRdataReg <= {11'h000, stateReg != eac_pkg::S_IDLE, 1'b0, statusReg};
        `EAC_SW_MASK:   swRdataReg <= {13'h0000, maskReg};
        default:        swRdataReg <= 16'h0000;
      endcase
    end
  end

  assign swRdata = swRdataReg;
  assign irq     = |(statusReg & maskReg);

endmodule : eac_host

// File: src/eac_consts.svh
// Functional notes
// - Write starts only after master enable armed
// - Master enable expires after four clock cycles
// - Arm with one write: enable set, strobe clear
// - Wait for write strobe low before writing
// - No write while flash self-programming busy
// - Address and data loads optional, any order
// - Write strobe self-clears after write time
// - Write strobe stalls CPU two cycles
// - Read strobe loads data register at once
// - Read stalls CPU four cycles
// - During write: reads ignored, address frozen
// - Check write strobe low before reading
// - Write lasts 8448 cycles of 1 MHz
// - Keep arm and strobe uninterrupted
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH

// ****************************************
// Device register map (interface side)
// ****************************************
`define EAC_REG_ADDRL     2'h0
`define EAC_REG_ADDRH     2'h1
`define EAC_REG_DATA      2'h2
`define EAC_REG_CTRL      2'h3
`define EAC_BIT_RE        0
`define EAC_BIT_WE        1
`define EAC_BIT_MWE       2

// ****************************************
// Host software register map
// ****************************************
`define EAC_SW_CMD        3'h0
`define EAC_SW_ADDR       3'h1
`define EAC_SW_DATA       3'h2
`define EAC_SW_RDATA      3'h3
`define EAC_SW_STATUS     3'h4
`define EAC_SW_MASK       3'h5
`define EAC_CMD_WRITE     0
`define EAC_CMD_READ      1
`define EAC_ST_WDONE      0
`define EAC_ST_RDONE      1
`define EAC_ST_WFAIL      2
`define EAC_ST_BUSY       4
`define EAC_RST_MASK      3'h0

// ****************************************
// Sizes and timing
// ****************************************
`define EAC_ADDR_W        9
`define EAC_DEPTH         512
`define EAC_MWE_CYCLES    3'h4
`define EAC_WSTALL_CYCLES 3'h2
`define EAC_RSTALL_CYCLES 3'h4
`define EAC_SYS_CLK_KHZ   100000
`define EAC_OSC_KHZ       1000
`define EAC_OSC_DIV       (`EAC_SYS_CLK_KHZ / `EAC_OSC_KHZ)
`define EAC_WRITE_OSC_CYC 8448

`endif

// File: src/eac_pkg.sv
// ****************************************
// Shared types
// ****************************************
package eac_pkg;
  typedef logic [1:0] eac_reg_sel_t;

  // Host sequencer states, one-hot
  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_CHK  = 11'h002,
    S_CHKW = 11'h004,
    S_LDAL = 11'h008,
    S_LDAH = 11'h010,
    S_LDD  = 11'h020,
    S_ARM  = 11'h040,
    S_STB  = 11'h080,
    S_DNC  = 11'h100,
    S_DNW  = 11'h200,
    S_RDS  = 11'h400
  } eac_host_state_t;

  // Read fetch steps, one-hot
  typedef enum logic [2:0] {
    R_IDLE  = 3'h1,
    R_FETCH = 3'h2,
    R_CAPT  = 3'h4
  } eac_rd_state_t;
endpackage : eac_pkg

// File: src/eac_if.sv
`timescale 1ns/10ps
// ****************************************
// Register link between CPU side and store
// ****************************************
interface eac_if;
  eac_pkg::eac_reg_sel_t regSel;
  logic [7:0]            regWdata;
  logic                  regWr;
  logic                  regRd;
  logic [7:0]            regRdata;
  logic                  stall;
  logic                  selfProgBusy;

  modport device (
    input  regSel,
    input  regWdata,
    input  regWr,
    input  regRd,
    output regRdata,
    output stall,
    output selfProgBusy
  );

  modport host (
    output regSel,
    output regWdata,
    output regWr,
    output regRd,
    input  regRdata,
    input  stall,
    input  selfProgBusy
  );
endinterface : eac_if

// File: src/eac_device.sv
`timescale 1ns/10ps
`include "eac_consts.svh"
// ****************************************
// Nonvolatile store with access control
// ****************************************
module eac_device #(
  parameter int ADDR_W     = `EAC_ADDR_W,
  parameter int DEPTH      = `EAC_DEPTH,
  parameter int OSC_DIV    = `EAC_OSC_DIV,
  parameter int WRITE_OSC  = `EAC_WRITE_OSC_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic selfProgBusyIn,
  output logic      writeBusy,
  eac_if.device     bus
);

  localparam int DIV_W = $clog2(OSC_DIV + 1);
  localparam int OSC_W = $clog2(WRITE_OSC + 1);

  // ****************************************
  // Decode helpers
  // ****************************************
  // True for a write to the given register
  function automatic logic regWrHit(input logic wr, input eac_pkg::eac_reg_sel_t sel,
                                    input eac_pkg::eac_reg_sel_t target);
    regWrHit = wr && (sel == target);
  endfunction : regWrHit

  // ****************************************
  // State
  // ****************************************
  logic [ADDR_W-1:0] addrReg;
  logic [7:0]        dataReg;
  logic [2:0]        mweCntReg;
  logic              busyReg;
  logic [2:0]        stallCntReg;
  logic [DIV_W-1:0]  divCntReg;
  logic [OSC_W-1:0]  oscCntReg;
  logic [ADDR_W-1:0] wrAddrReg;
  logic [7:0]        wrDataReg;
  logic [7:0]        rdataReg;
  logic [7:0]        mem [DEPTH];

  logic ctrlWr;
  logic armReq;
  logic strobeReq;
  logic mweActive;
  logic writeStart;
  logic readStart;
  logic oscTick;
  logic writeEnd;

  // ****************************************
  // Control register decode
  // ****************************************
  // Enable bit written with strobe clear arms; strobe bit set fires
  assign ctrlWr    = regWrHit(bus.regWr, bus.regSel, `EAC_REG_CTRL);
  assign armReq    = ctrlWr && bus.regWdata[`EAC_BIT_MWE]
                     && !bus.regWdata[`EAC_BIT_WE];
  assign strobeReq = ctrlWr && bus.regWdata[`EAC_BIT_WE];
  assign mweActive = (mweCntReg != 3'h0);
  // A strobe without a live arm is dropped silently
  assign writeStart = strobeReq && mweActive && !busyReg
                      && !selfProgBusyIn;
  // Write has priority; a read strobe during a write does nothing
  assign readStart = ctrlWr && bus.regWdata[`EAC_BIT_RE] && !busyReg
                     && !writeStart;

  // ****************************************
  // Master enable window
  // ****************************************
  // Window opens for four cycles and closes on use or expiry
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mweCntReg <= 3'h0;
    end else if (armReq) begin
      mweCntReg <= `EAC_MWE_CYCLES;
    end else if (strobeReq) begin
      mweCntReg <= 3'h0;
    end else if (mweActive) begin
      mweCntReg <= mweCntReg - 3'h1;
    end
  end

  // ****************************************
  // Write timing from the 1 MHz reference
  // ****************************************
  // Divider makes the reference tick from the system clock, so the
  // write time scales with the system clock rate and OSC_DIV must match it
  assign oscTick  = busyReg && (divCntReg == DIV_W'(OSC_DIV - 1));
  assign writeEnd = oscTick && (oscCntReg == OSC_W'(WRITE_OSC - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      divCntReg <= '0;
    end else if (!busyReg || oscTick) begin
      divCntReg <= '0;
    end else begin
      divCntReg <= divCntReg + DIV_W'(1);
    end
  end

  // Reference cycles elapsed in the current write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      oscCntReg <= '0;
    end else if (writeStart) begin
      oscCntReg <= '0;
    end else if (oscTick) begin
      oscCntReg <= oscCntReg + OSC_W'(1);
    end
  end

  // ****************************************
  // Write in progress flag
  // ****************************************
  // Reads back as the strobe bit; clears itself when time is up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busyReg <= 1'b0;
    end else if (writeStart) begin
      busyReg <= 1'b1;
    end else if (writeEnd) begin
      busyReg <= 1'b0;
    end
  end

  // Snapshot of target taken when the strobe is accepted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrAddrReg <= '0;
      wrDataReg <= 8'h00;
    end else if (writeStart) begin
      wrAddrReg <= addrReg;
      wrDataReg <= dataReg;
    end
  end

  // ****************************************
  // Storage array
  // ****************************************
  // Cells change only at the end of the write time, as a real cell would
  always_ff @(posedge sys_clk) begin
    if (writeEnd) begin
      mem[wrAddrReg] <= wrDataReg;
    end
  end

  // ****************************************
  // Address and data registers
  // ****************************************
  // Address is frozen while a write runs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addrReg <= '0;
    end else if (!busyReg) begin
      if (regWrHit(bus.regWr, bus.regSel, `EAC_REG_ADDRL)) begin
        addrReg[7:0] <= bus.regWdata;
      end else if (regWrHit(bus.regWr, bus.regSel, `EAC_REG_ADDRH)) begin
        addrReg[ADDR_W-1:8] <= bus.regWdata[ADDR_W-9:0];
      end
    end
  end

  // Data register takes CPU writes and read results
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dataReg <= 8'h00;
    end else if (readStart) begin
      dataReg <= mem[addrReg];
    end else if (regWrHit(bus.regWr, bus.regSel, `EAC_REG_DATA)) begin
      dataReg <= bus.regWdata;
    end
  end

  // ****************************************
  // CPU stall
  // ****************************************
  // Stall starts the cycle after the strobe; the host must hold off
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stallCntReg <= 3'h0;
    end else if (writeStart) begin
      stallCntReg <= `EAC_WSTALL_CYCLES;
    end else if (readStart) begin
      stallCntReg <= `EAC_RSTALL_CYCLES;
    end else if (stallCntReg != 3'h0) begin
      stallCntReg <= stallCntReg - 3'h1;
    end
  end

  assign bus.stall = (stallCntReg != 3'h0);

  // ****************************************
  // Read-back path
  // ****************************************
  // One cycle latency; read strobe bit always reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdataReg <= 8'h00;
    end else if (bus.regRd) begin
      case (bus.regSel)
        `EAC_REG_ADDRL: begin
          rdataReg <= addrReg[7:0];
        end
        `EAC_REG_ADDRH: begin
          rdataReg <= 8'(addrReg[ADDR_W-1:8]);
        end
        `EAC_REG_DATA: begin
          rdataReg <= dataReg;
        end
        default: begin
          rdataReg <= {5'h00, mweActive, busyReg, 1'b0};
        end
      endcase
    end
  end

  assign bus.regRdata      = rdataReg;
  assign bus.selfProgBusy  = selfProgBusyIn;
  assign writeBusy         = busyReg;

endmodule : eac_device

// File: verif/eac_props.sv
`timescale 1ns/10ps
// ****************************************
// Checker on the link between the two ends
// ****************************************
module eac_props #(
  parameter int OSC_DIV   = 4,
  parameter int WRITE_OSC = 3
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire eac_pkg::eac_reg_sel_t regSel,
  input wire logic [7:0]            regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [7:0]            regRdata,
  input wire logic                  stall,
  input wire logic                  selfProgBusy
);
  logic       ctrlWr;
  logic       wrAcc;
  logic       rdAcc;
  logic       anyAcc;
  logic       busyNow;
  logic       winOpen;
  logic [2:0] winReg;
  int         busyReg;

  // Strobe acceptance as the store must judge it
  assign ctrlWr  = regWr && (regSel == 2'h3);
  assign busyNow = (busyReg != 0);
  assign winOpen = (winReg != 3'h0);
  assign wrAcc   = ctrlWr && regWdata[1] && winOpen && !busyNow && !selfProgBusy;
  assign rdAcc   = ctrlWr && regWdata[0] && !regWdata[1] && !busyNow;
  assign anyAcc  = wrAcc || rdAcc;

  // Arm window; any write strobe closes it, taken or not
  always_ff @(posedge sys_clk) begin
    if (!rst_n) winReg <= 3'h0;
    else if (ctrlWr && regWdata[1]) winReg <= 3'h0;
    else if (ctrlWr && regWdata[2]) winReg <= 3'h4;
    else if (winOpen) winReg <= winReg - 3'h1;
  end

  // Write time counted in system clocks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) busyReg <= 0;
    else if (wrAcc) busyReg <= OSC_DIV * WRITE_OSC;
    else if (busyNow) busyReg <= busyReg - 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_wr_stall;
    wrAcc |=> stall [*2] ##1 !stall;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");
  property p_rd_stall;
    rdAcc |=> stall [*4] ##1 !stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");
  property p_stall_cause;
    $rose(stall) |-> $past(anyAcc);
  endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without strobe");
  property p_spm_refuse;
    ctrlWr && regWdata[1] && !regWdata[0] && selfProgBusy |=> !stall;
  endproperty
  a_spm_refuse: assert property (p_spm_refuse) else $error("write taken in flash busy");
  property p_ctrl_busy;
    regRd && (regSel == 2'h3) |=> (regRdata[1] == $past(busyNow)) && !regRdata[0];
  endproperty
  a_ctrl_busy: assert property (p_ctrl_busy) else $error("strobe bits read wrong");
  property p_ctrl_window;
    regRd && (regSel == 2'h3) |=> regRdata[2] == $past(winOpen);
  endproperty
  a_ctrl_window: assert property (p_ctrl_window) else $error("enable bit read wrong");
  property p_host_quiet;
    stall |-> !regWr && !regRd;
  endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("access during stall");
  property p_rdata_hold;
    !$past(regRd) |-> $stable(regRdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // Main scenarios
  c_write: cover property (wrAcc);
  c_read:  cover property (rdAcc);
  c_spm:   cover property (ctrlWr && regWdata[1] && selfProgBusy);
endmodule : eac_props

// File: verif/tb_top.sv
`timescale 1ns/10ps
`include "eac_consts.svh"
module tb_top;
  typedef struct packed {logic [15:0] e; logic [15:0] m;} eac_note_t;
  localparam int DIV  = 4;
  localparam int WOSC = 3;
  logic        sys_clk;
  logic        rst_n;
  logic        spbIn;
  logic        swWr;
  logic        swRd;
  logic        rdPend;
  logic        irq;
  logic        writeBusy;
  logic [2:0]  swAddr;
  logic [15:0] swWdata;
  logic [15:0] swRdata;
  logic [8:0]  adr [4];
  logic [7:0]  memExp [int];
  logic [7:0]  oldByte;
  eac_note_t   notes [$];
  eac_note_t   nt;
  int          numErrors;
  int          totalChecks;
  int          seed;
  int          n;

  eac_if bus ();
  eac_device #(.OSC_DIV(DIV), .WRITE_OSC(WOSC)) i_eac_device (.sys_clk(sys_clk),
    .rst_n(rst_n), .selfProgBusyIn(spbIn), .writeBusy(writeBusy), .bus(bus));
  eac_host i_eac_host (.sys_clk(sys_clk), .rst_n(rst_n), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .irq(irq), .bus(bus));
  eac_props #(.OSC_DIV(DIV), .WRITE_OSC(WOSC)) i_eac_props (.sys_clk(sys_clk),
    .rst_n(rst_n), .regSel(bus.regSel), .regWdata(bus.regWdata), .regWr(bus.regWr),
    .regRd(bus.regRd), .regRdata(bus.regRdata), .stall(bus.stall),
    .selfProgBusy(bus.selfProgBusy));

  // Clock
  always #5 sys_clk = ~sys_clk;

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic check_word(input string s, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : check_word

  task automatic check_bit(input string s, input logic e, input logic g);
    check_word(s, {15'h0000, e}, {15'h0000, g});
  endtask : check_bit

  task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    swAddr  <= a;
    swWdata <= d;
    swWr    <= 1'b1;
    @(posedge sys_clk);
    swWr <= 1'b0;
  endtask : sw_wr

  // Expected value goes to the queue; the monitor compares
  task automatic sw_rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge sys_clk);
    swAddr <= a;
    swRd   <= 1'b1;
    notes.push_back('{e, m});
    @(posedge sys_clk);
    swRd <= 1'b0;
  endtask : sw_rd

  // Bounded wait on irq or on the write busy flag
  task automatic wait_for(input bit useBusy, input logic e);
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge sys_clk);
      if ((useBusy ? writeBusy : irq) === e) break;
    end
    check_bit(useBusy ? "writeBusy" : "irq", e, useBusy ? writeBusy : irq);
  endtask : wait_for

  task automatic do_write(input logic [8:0] a, input logic [7:0] d);
    sw_wr(`EAC_SW_ADDR, {7'h00, a});
    sw_wr(`EAC_SW_DATA, {8'h00, d});
    sw_wr(`EAC_SW_CMD, 16'h0001);
    memExp[a] = d;
  endtask : do_write

  task automatic finish_op(input logic [15:0] st);
    wait_for(1'b0, 1'b1);
    sw_rd(`EAC_SW_STATUS, st, 16'h0017);
    sw_wr(`EAC_SW_STATUS, 16'h0007);
    wait_for(1'b0, 1'b0);
  endtask : finish_op

  task automatic do_read(input logic [8:0] a);
    sw_wr(`EAC_SW_ADDR, {7'h00, a});
    sw_wr(`EAC_SW_CMD, 16'h0002);
    finish_op(16'h0002);
    sw_rd(`EAC_SW_RDATA, {8'h00, memExp[a]}, 16'h00FF);
  endtask : do_read

  task automatic stop_test;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // Monitor: read data are checked in the cycle after the strobe; they hold until the next read
  always @(posedge sys_clk) begin
    if (rdPend === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      check_word("swRdata", nt.e & nt.m, swRdata & nt.m);
    end
    rdPend <= swRd;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    numErrors++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    spbIn = 1'b0;
    swWr = 1'b0;
    swRd = 1'b0;
    swAddr = 3'h0;
    swWdata = 16'h0000;
    seed = 39933;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    sw_rd(`EAC_SW_MASK, 16'h0000, 16'hFFFF);
    sw_rd(`EAC_SW_STATUS, 16'h0000, 16'hFFFF);
    sw_rd(3'h7, 16'h0000, 16'hFFFF);
    sw_wr(`EAC_SW_MASK, 16'h0007);
    // Writes at both ends of the array and at random places
    adr[0] = 9'h000;
    adr[1] = 9'h1FF;
    adr[2] = 9'(($random(seed) & 32'h0FF) | 32'h100);
    adr[3] = 9'($random(seed) & 32'h0FF);
    foreach (adr[i]) begin
      do_write(adr[i], 8'($random(seed)));
      sw_wr(`EAC_SW_ADDR, {7'h00, ~adr[i]});
      sw_rd(`EAC_SW_ADDR, {7'h00, adr[i]}, 16'h01FF);
      wait_for(1'b1, 1'b1);
      finish_op(16'h0001);
    end
    foreach (adr[i]) do_read(adr[i]);
    // Masked completion shows in status but not on irq
    sw_wr(`EAC_SW_MASK, 16'h0000);
    do_write(adr[3], 8'($random(seed)));
    wait_for(1'b1, 1'b1);
    wait_for(1'b1, 1'b0);
    repeat (10) @(posedge sys_clk);
    check_bit("irq", 1'b0, irq);
    sw_rd(`EAC_SW_STATUS, 16'h0001, 16'h0017);
    sw_wr(`EAC_SW_MASK, 16'h0007);
    finish_op(16'h0001);
    // Flash busy before the command holds the write back
    @(posedge sys_clk);
    spbIn <= 1'b1;
    do_write(adr[1], 8'($random(seed)));
    repeat (40) @(posedge sys_clk);
    check_bit("writeBusy", 1'b0, writeBusy);
    sw_rd(`EAC_SW_STATUS, 16'h0010, 16'h0017);
    spbIn <= 1'b0;
    wait_for(1'b1, 1'b1);
    n = 0;
    while (writeBusy === 1'b1 && n < 200) begin
      n++;
      @(negedge sys_clk);
    end
    check_word("writeTime", 16'(DIV * WOSC), 16'(n));
    finish_op(16'h0001);
    // Flash busy rising mid-sequence makes the strobe fail
    oldByte = memExp[adr[2]];
    do_write(adr[2], ~memExp[adr[2]]);
    for (n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      if (bus.regWr === 1'b1 && bus.regSel === 2'h0) break;
    end
    @(posedge sys_clk);
    spbIn <= 1'b1;
    wait_for(1'b0, 1'b1);
    @(posedge sys_clk);
    spbIn <= 1'b0;
    memExp[adr[2]] = oldByte;
    finish_op(16'h0004);
    do_read(adr[2]);
    repeat (5) @(posedge sys_clk);
    stop_test();
  end
endmodule : tb_top
